// ### src/iodc_ctrl.v
// Register bank and apply logic of the integer output divider control.
`timescale 1ns/1ps
`include "iodc_map.vh"

// Three-stage synchroniser for a level from the oscillator domain, with a rising-edge pulse.
module iodc_sync (
  input  wire clk,
  input  wire rst_n,
  input  wire pin_in,
  output wire rise
);
  localparam STAGES = `IODC_SYNC_STAGES;

  reg  [STAGES-1:0] stage_reg;
  reg  [STAGES-1:0] stage_next;
  reg               stable_reg;
  reg               stable_next;
  wire              agree;

  // A change counts only once the second and third stages hold the same level.
  assign agree = (stage_reg[1] == stage_reg[2]);
  assign rise  = agree & stage_reg[2] & ~stable_reg;

  always @* begin
    stage_next  = {stage_reg[STAGES-2:0], pin_in};
    stable_next = stable_reg;
    if (agree) begin
      stable_next = stage_reg[2];
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      stage_reg  <= {STAGES{1'b0}};
      stable_reg <= `IODC_BIT_RESET;
    end else begin
      stage_reg  <= stage_next;
      stable_reg <= stable_next;
    end
  end
endmodule

// Register bank of one integer output divider, reached over Avalon-MM with one wait cycle.
module iodc_ctrl #(
  parameter RATIO_W = `IODC_RATIO_W,
  parameter PHASE_W = `IODC_PHASE_W
) (
  input  wire               clk,
  input  wire               rst_n,
  input  wire [2:0]         avs_address,
  input  wire               avs_read,
  input  wire               avs_write,
  input  wire [31:0]        avs_writedata,
  input  wire [3:0]         avs_byteenable,
  output reg  [31:0]        avs_readdata,
  output wire               avs_waitrequest,
  output wire [1:0]         avs_response,
  input  wire               div_sync,
  input  wire               phase_done,
  output wire               divider_power_down,
  output wire               divider_disable,
  output wire               divider_reset,
  output reg  [RATIO_W-1:0] div_ratio,
  output reg                ratio_load,
  output reg  [PHASE_W-1:0] phase_offset,
  output reg                phase_apply,
  output wire               phase_busy
);
  localparam [1:0] TRIG_IDLE = 2'h1;
  localparam [1:0] TRIG_BUSY = 2'h2;

  reg                ack_reg;
  reg                ack_next;

  reg                pd_reg;
  reg                pd_next;
  reg                dis_reg;
  reg                dis_next;
  reg                rst_reg;
  reg                rst_next;
  reg  [RATIO_W-1:0] ratio_reg;
  reg  [RATIO_W-1:0] ratio_next;
  reg  [RATIO_W-1:0] div_ratio_next;
  reg                ratio_load_next;

  reg  [PHASE_W-1:0] phase_reg;
  reg  [PHASE_W-1:0] phase_next;
  reg  [PHASE_W-1:0] phase_offset_next;
  reg                on_sync_reg;
  reg                on_sync_next;
  reg                phase_apply_next;
  reg  [1:0]         trig_state_reg;
  reg  [1:0]         trig_state_next;

  reg  [31:0]        ratio_word;
  reg  [31:0]        phase_word;
  reg  [31:0]        readdata_next;
  wire [31:0]        ratio_merge;
  wire [31:0]        phase_merge;
  wire               hit_ratio;
  wire               hit_phase;
  wire               rd_first;
  wire               wr_commit;
  wire               ratio_commit;
  wire               ratio_top;
  wire               phase_commit;
  wire               phase_top;
  wire               trig_write;
  wire               trig_fire;
  wire               sync_rise;
  wire               done_rise;

  // Merges the enabled byte lanes of a write into the word that software reads back.
  function [31:0] lane_merge;
    input [31:0] old_word;
    input [31:0] new_word;
    input [3:0]  lanes;
    integer      i;
    begin
      lane_merge = old_word;
      for (i = 0; i < `IODC_LANES; i = i + 1) begin
        if (lanes[i]) begin
          lane_merge[i*`IODC_LANE_W +: `IODC_LANE_W] = new_word[i*`IODC_LANE_W +: `IODC_LANE_W];
        end
      end
    end
  endfunction

  function word_hit;
    input [2:0] addr;
    input [2:0] offset;
    begin
      word_hit = (addr == offset);
    end
  endfunction

  assign hit_ratio    = word_hit(avs_address, `IODC_OFS_RATIO);
  assign hit_phase    = word_hit(avs_address, `IODC_OFS_PHASE);
  // Reads are looked up in the first cycle; writes land in the cycle waitrequest is low.
  assign rd_first     = avs_read & ~ack_reg;
  assign wr_commit    = avs_write & ack_reg;
  assign ratio_commit = wr_commit & hit_ratio;
  assign ratio_top    = ratio_commit & avs_byteenable[`IODC_LANE_TOP];
  assign phase_commit = wr_commit & hit_phase;
  assign phase_top    = phase_commit & avs_byteenable[`IODC_LANE_PHASE];
  assign ratio_merge  = lane_merge(ratio_word, avs_writedata, avs_byteenable);
  assign phase_merge  = lane_merge(phase_word, avs_writedata, avs_byteenable);
  assign trig_write   = phase_top & avs_writedata[`IODC_BIT_NOW];
  // A one written while busy counts only if the finish arrives in the same cycle.
  assign trig_fire    = trig_write & ((trig_state_reg == TRIG_IDLE) | done_rise);

  assign avs_waitrequest    = (avs_read | avs_write) & ~ack_reg;
  assign avs_response       = `IODC_RESP_OKAY;
  assign divider_power_down = pd_reg;
  assign divider_disable    = dis_reg;
  assign divider_reset      = rst_reg;
  assign phase_busy         = (trig_state_reg == TRIG_BUSY);

  iodc_sync sync_of_div (
    .clk    (clk),
    .rst_n  (rst_n),
    .pin_in (div_sync),
    .rise   (sync_rise)
  );

  iodc_sync sync_of_done (
    .clk    (clk),
    .rst_n  (rst_n),
    .pin_in (phase_done),
    .rise   (done_rise)
  );

  // Every access is answered one cycle after it is presented.
  always @* begin
    ack_next = (avs_read | avs_write) & ~ack_reg;
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      ack_reg <= `IODC_BIT_RESET;
    end else begin
      ack_reg <= ack_next;
    end
  end

  always @* begin
    pd_next  = pd_reg;
    dis_next = dis_reg;
    rst_next = rst_reg;
    if (ratio_commit) begin
      pd_next  = ratio_merge[`IODC_BIT_PD];
      dis_next = ratio_merge[`IODC_BIT_DIS];
      rst_next = ratio_merge[`IODC_BIT_RST];
    end
  end

  always @* begin
    ratio_next      = ratio_reg;
    div_ratio_next  = div_ratio;
    ratio_load_next = 1'b0;
    if (ratio_commit) begin
      // Lower lanes are only stored; the divider keeps its ratio until the top lane comes.
      ratio_next = ratio_merge[`IODC_RATIO_MSB:0];
    end
    if (ratio_top) begin
      div_ratio_next  = ratio_merge[`IODC_RATIO_MSB:0];
      ratio_load_next = 1'b1;
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      pd_reg  <= `IODC_BIT_RESET;
      dis_reg <= `IODC_BIT_RESET;
      rst_reg <= `IODC_BIT_RESET;
    end else begin
      pd_reg  <= pd_next;
      dis_reg <= dis_next;
      rst_reg <= rst_next;
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      ratio_reg  <= `IODC_RATIO_RESET;
      div_ratio  <= `IODC_RATIO_RESET;
      ratio_load <= `IODC_BIT_RESET;
    end else begin
      ratio_reg  <= ratio_next;
      div_ratio  <= div_ratio_next;
      ratio_load <= ratio_load_next;
    end
  end

  always @* begin
    phase_next   = phase_reg;
    on_sync_next = on_sync_reg;
    if (phase_commit) begin
      phase_next   = phase_merge[`IODC_PHASE_MSB:0];
      on_sync_next = phase_merge[`IODC_BIT_ON_SYNC];
    end
  end

  always @* begin
    phase_offset_next = phase_offset;
    if (phase_top) begin
      // Signed offset in oscillator periods, handed over whole.
      phase_offset_next = phase_merge[`IODC_PHASE_MSB:0];
    end
  end

  always @* begin
    phase_apply_next = 1'b0;
    if (sync_rise && on_sync_reg) begin
      phase_apply_next = 1'b1;
    end
    if (trig_fire) begin
      phase_apply_next = 1'b1;
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      phase_reg   <= `IODC_PHASE_RESET;
      on_sync_reg <= `IODC_BIT_RESET;
    end else begin
      phase_reg   <= phase_next;
      on_sync_reg <= on_sync_next;
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      phase_offset <= `IODC_PHASE_RESET;
      phase_apply  <= `IODC_BIT_RESET;
    end else begin
      phase_offset <= phase_offset_next;
      phase_apply  <= phase_apply_next;
    end
  end

  // Trigger bit: set by writing one, cleared when the adjustment reports it has finished.
  always @* begin
    trig_state_next = trig_state_reg;
    case (trig_state_reg)
      TRIG_IDLE: begin
        if (trig_fire) begin
          trig_state_next = TRIG_BUSY;
        end
      end
      TRIG_BUSY: begin
        if (done_rise && !trig_fire) begin
          trig_state_next = TRIG_IDLE;
        end
      end
      default: begin
        trig_state_next = TRIG_IDLE;
      end
    endcase
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      trig_state_reg <= TRIG_IDLE;
    end else begin
      trig_state_reg <= trig_state_next;
    end
  end

  // Reserved fields stay zero in both words, so writes to them have no effect.
  always @* begin
    ratio_word                    = `IODC_READ_RESET;
    ratio_word[`IODC_BIT_PD]      = pd_reg;
    ratio_word[`IODC_BIT_DIS]     = dis_reg;
    ratio_word[`IODC_BIT_RST]     = rst_reg;
    ratio_word[`IODC_RATIO_MSB:0] = ratio_reg;
  end

  always @* begin
    phase_word                    = `IODC_READ_RESET;
    phase_word[`IODC_BIT_NOW]     = phase_busy;
    phase_word[`IODC_BIT_ON_SYNC] = on_sync_reg;
    phase_word[`IODC_PHASE_MSB:0] = phase_reg;
  end

  // Read data is fetched in the wait cycle and stands while waitrequest is low.
  always @* begin
    readdata_next = avs_readdata;
    if (rd_first) begin
      readdata_next = `IODC_READ_RESET;
      if (hit_ratio) begin
        readdata_next = ratio_word;
      end else if (hit_phase) begin
        readdata_next = phase_word;
      end
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      avs_readdata <= `IODC_READ_RESET;
    end else begin
      avs_readdata <= readdata_next;
    end
  end
endmodule

// ### src/iodc_map.vh
// Register map, field layout and reset values of the integer output divider control.
`ifndef IODC_MAP_VH
`define IODC_MAP_VH
`define IODC_OFS_RATIO     3'h0
`define IODC_OFS_PHASE     3'h4
`define IODC_RATIO_W       25
`define IODC_PHASE_W       9
`define IODC_LANES         4
`define IODC_LANE_W        8
`define IODC_LANE_TOP      3
`define IODC_LANE_PHASE    1
`define IODC_SYNC_STAGES   3
`define IODC_BIT_RESET     1'b0
`define IODC_READ_RESET    32'h00000000
`define IODC_RESP_OKAY     2'h0
`define IODC_BIT_PD        31
`define IODC_BIT_DIS       30
`define IODC_BIT_RST       29
`define IODC_RATIO_MSB     24
`define IODC_RATIO_RESET   25'h0000064
`define IODC_BIT_NOW       15
`define IODC_BIT_ON_SYNC   14
`define IODC_PHASE_MSB     8
`define IODC_PHASE_RESET   9'h000
`endif

// ### tb/iodc_checker.sv
// Port checks of the divider control block.
`timescale 1ns/1ps
module iodc_checker (
  input wire        clk, rst_n, avs_read, avs_write, avs_waitrequest,
  input wire        ratio_load, phase_apply, phase_busy, phase_done,
  input wire        divider_power_down, divider_disable, divider_reset,
  input wire [2:0]  avs_address,
  input wire [31:0] avs_writedata,
  input wire [3:0]  avs_byteenable,
  input wire [24:0] div_ratio,
  input wire [8:0]  phase_offset
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire acc = avs_write && !avs_waitrequest;
  wire wr0 = acc && avs_address == 3'h0 && avs_byteenable[3];
  wire wr4 = acc && avs_address == 3'h4 && avs_byteenable[1];
  chk_wait_first: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
    else $error("no wait cycle");
  chk_ratio_apply: assert property (wr0 && avs_byteenable == 4'hf |=> ratio_load &&
    div_ratio == $past(avs_writedata[24:0])) else $error("ratio not applied");
  chk_ratio_hold: assert property (!ratio_load |-> $stable(div_ratio))
    else $error("ratio moved");
  chk_ctrl_bits: assert property (wr0 |=> {divider_power_down, divider_disable,
    divider_reset} == $past(avs_writedata[31:29])) else $error("control bits wrong");
  chk_phase_take: assert property (wr4 && avs_byteenable[0] |=>
    phase_offset == $past(avs_writedata[8:0])) else $error("phase wrong");
  chk_now_trigger: assert property (wr4 && avs_writedata[15] && !phase_busy |=>
    phase_apply && phase_busy) else $error("trigger lost");
  chk_busy_clear: assert property ($rose(phase_done) |-> ##[1:6] !phase_busy)
    else $error("trigger not cleared");
  chk_load_cause: assert property (ratio_load |-> $past(wr0))
    else $error("stray ratio load");
  cover property (wr0);
  cover property (wr4 && avs_writedata[15]);
  cover property ($rose(phase_done) ##[1:6] !phase_busy);
endmodule
bind iodc_ctrl iodc_checker chk (.*);

// ### tb/iodc_ctrl_test.sv
// Register-level test of the divider control block.
`timescale 1ns/1ps
module iodc_ctrl_test;
  reg         clk = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  reg         div_sync = 1'b0, phase_done = 1'b0;
  reg  [2:0]  avs_address = 3'h0;
  reg  [31:0] avs_writedata = 32'h0, r;
  reg  [3:0]  avs_byteenable = 4'h0;
  wire [31:0] avs_readdata;
  wire [1:0]  avs_response;
  wire        avs_waitrequest, ratio_load, phase_apply, phase_busy;
  wire        divider_power_down, divider_disable, divider_reset;
  wire [24:0] div_ratio;
  wire [8:0]  phase_offset;
  integer     bad_count = 0, tests_run = 0, n = 0;
  always #25 clk = ~clk;
  always @(posedge clk) if (phase_apply === 1'b1) n <= n + 1;
  iodc_ctrl uut (.*);
  wire [2:0] ctl = {divider_power_down, divider_disable, divider_reset};
  task chk(input string s, input [31:0] v, input [31:0] e);
    tests_run = tests_run + 1;
    if (v !== e) begin
      bad_count = bad_count + 1;
      $display("Error %s expected %h seen %h", s, e, v);
    end
  endtask
  task acc(input w, input [2:0] a, input [31:0] d, input [3:0] be);
    @(posedge clk);
    avs_write <= w;
    avs_read <= !w;
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    r = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    repeat (2) @(negedge clk);
  endtask
  task hit(input [1:0] v);
    @(posedge clk);
    {div_sync, phase_done} <= v;
    repeat (8) @(posedge clk);
    {div_sync, phase_done} <= 2'b00;
    repeat (8) @(posedge clk);
    @(negedge clk);
  endtask
  task report_and_stop;
    if (bad_count == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clk);
    bad_count = bad_count + 1;
    report_and_stop;
  end
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    acc(0, 3'h0, 0, 4'hf);
    chk("ratio", r, 32'h00000064);
    acc(1, 3'h0, 32'hfe000020, 4'h7);
    chk("ratio", div_ratio, 32'h64);
    acc(1, 3'h0, 32'hfe000000, 4'h8);
    chk("ctl", ctl, 3'h7);
    chk("ratio", div_ratio, 32'h20);
    acc(0, 3'h0, 0, 4'hf);
    chk("ratio", r, 32'he0000020);
    acc(1, 3'h0, 32'h2000000e, 4'hf);
    chk("ctl", ctl, 3'h1);
    acc(1, 3'h0, 32'h0000000e, 4'h8);
    chk("ctl", ctl, 3'h0);
    acc(1, 3'h4, 32'h0000ffff, 4'h3);
    chk("phase", phase_offset, 32'h1ff);
    chk("apply", n, 1);
    acc(0, 3'h4, 0, 4'hf);
    chk("phase", r, 32'h0000c1ff);
    hit(2'b01);
    chk("busy", phase_busy, 0);
    hit(2'b10);
    chk("apply", n, 2);
    acc(1, 3'h4, 32'h00000005, 4'h1);
    chk("phase", phase_offset, 32'h1ff);
    acc(1, 3'h4, 32'h00000005, 4'h2);
    chk("phase", phase_offset, 32'h5);
    hit(2'b10);
    chk("apply", n, 2);
    acc(1, 3'h6, 32'hffffffff, 4'hf);
    acc(0, 3'h6, 0, 4'hf);
    chk("hole", r, 0);
    chk("resp", avs_response, 0);
    report_and_stop;
  end
endmodule
